// ### verilog/tad_map.svh
`ifndef TAD_MAP_SVH
`define TAD_MAP_SVH
// Mode enable bits
`define TAD_DCR_ADV_BIT 11
`define TAD_MSR_ADV_BIT 15
`define TAD_DSR_TXN_BIT 16
// Abort status layout
`define TAD_ST_EXPLICIT_BIT 0
`define TAD_ST_DEBUG_BIT 4
`define TAD_ST_ARG_LSB 24
// Register offsets
`define TAD_REG_CTRL 12'h000
`define TAD_REG_STATUS 12'h004
`define TAD_REG_ABORT 12'h008
`define TAD_REG_COUNT 12'h00C
// Control fields and reset value
`define TAD_CTRL_IMPL_BIT 0
`define TAD_CTRL_MIX_BIT 1
`define TAD_CTRL_DIR_BIT 2
`define TAD_CTRL_RESET 32'h00000007
`endif

// ### verilog/tad_pkg.sv
package tad_pkg;
   // Instruction classes presented at retire
   typedef enum logic [3:0] {
      IC_NORMAL = 4'h0,
      IC_BEGIN = 4'h1,
      IC_END = 4'h2,
      IC_EXPL_ABORT = 4'h3,
      IC_ALWAYS = 4'h4,
      IC_SUSPEND = 4'h5,
      IC_RESUME = 4'h6,
      IC_DIR_CLR = 4'h7,
      IC_DIR_SET = 4'h8,
      IC_VEC128 = 4'h9,
      IC_VEC256 = 4'hA,
      IC_IMPLDEP = 4'hB,
      IC_FENCE = 4'hC
   } tad_class_t;
   // Transaction tracking state
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_ACTIVE = 2'b01,
      TX_SUSPEND = 2'b10
   } tad_state_t;
endpackage

// ### verilog/tad_instr_class.sv
`timescale 1ns/1ps
`default_nettype none
module tad_instr_class
   import tad_pkg::*;
(
   // Retired instruction
   input wire logic instrValid,
   input wire tad_class_t instrClass,
   input wire logic dirFlag,
   // Transaction context
   input wire logic txnActive,
   input wire logic suspendOpen,
   input wire logic depthFull,
   input wire logic used128,
   input wire logic used256,
   // Policy enables
   input wire logic implEn,
   input wire logic mixEn,
   input wire logic dirEn,
   // Decision
   output logic abortReq,
   output logic explicitAbort
);
   logic hit;

   // Abort decision per class
   always_comb
   begin
      hit = 1'b0;
      case (instrClass)
         IC_BEGIN: hit = suspendOpen | depthFull;
         IC_END: hit = suspendOpen;
         IC_SUSPEND: hit = suspendOpen;
         IC_EXPL_ABORT: hit = 1'b1;
         IC_ALWAYS: hit = 1'b1;
         IC_DIR_CLR: hit = dirEn & dirFlag;
         IC_DIR_SET: hit = dirEn & ~dirFlag;
         IC_VEC128: hit = mixEn & used256;
         IC_VEC256: hit = mixEn & used128;
         IC_IMPLDEP: hit = implEn;
         IC_FENCE: hit = 1'b0;
         IC_NORMAL: hit = 1'b0;
         default: hit = 1'b0;
      endcase
   end

   // Only instructions inside a transaction may abort
   assign abortReq = instrValid & txnActive & hit;
   assign explicitAbort = instrValid & txnActive
                        & (instrClass == IC_EXPL_ABORT);
endmodule
`default_nettype wire

// ### verilog/tad_abort_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tad_map.svh"
module tad_abort_ctrl
   import tad_pkg::*;
#(
   parameter int ADDR_W = 48,
   parameter int DEPTH_W = 3,
   parameter logic [DEPTH_W-1:0] MAX_NEST = 3'h7
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Retire stream
   input wire logic instrValid,
   input wire tad_class_t instrClass,
   input wire logic [7:0] instrImm,
   input wire logic dirFlag,
   // Exceptions and debug state
   input wire logic dbgExc,
   input wire logic bpExc,
   input wire logic [31:0] debugControlReg,
   input wire logic [31:0] debugCtlMsr,
   input wire logic [31:0] abortStatusIn,
   // Loads
   input wire logic loadValid,
   input wire logic [ADDR_W-1:0] loadAddr,
   // Read set update
   output logic readSetAdd,
   output logic [ADDR_W-1:0] readSetAddr,
   // Transaction outcome
   output logic txnActive,
   output logic suspendOpen,
   output logic abortPulse,
   output logic fallbackPulse,
   output logic rollbackPulse,
   output logic dbgDeliver,
   output logic dbgStatusClr,
   output logic archCommit,
   output logic [31:0] abortStatus
);
   tad_state_t state;
   tad_state_t next_state;
   logic [DEPTH_W-1:0] depth;
   logic [31:0] savedStatus;
   logic [31:0] next_status;
   logic [31:0] ctrl;
   logic [31:0] abortCount;
   logic used128;
   logic used256;
   logic inTxn;
   logic advMode;
   logic dbgHit;
   logic clsAbort;
   logic explicitAbort;
   logic abortNow;
   logic isBegin;
   logic isEnd;
   logic beginIdle;
   logic commitNow;
   logic apbWr;
   logic apbRd;
   logic mapped;

   // Advanced debug needs both enables
   assign advMode = debugControlReg[`TAD_DCR_ADV_BIT]
                  & debugCtlMsr[`TAD_MSR_ADV_BIT];
   assign inTxn = (state != TX_IDLE);
   assign dbgHit = inTxn & (dbgExc | bpExc);
   assign isBegin = instrValid & (instrClass == IC_BEGIN);
   assign isEnd = instrValid & (instrClass == IC_END);
   // No privilege check on transactional instructions
   assign beginIdle = isBegin & (state == TX_IDLE);
   assign abortNow = dbgHit | clsAbort;
   assign commitNow = isEnd & inTxn & ~abortNow & (depth == 1);

   // Instruction abort classifier
   tad_instr_class u_class (
      .instrValid(instrValid),
      .instrClass(instrClass),
      .dirFlag(dirFlag),
      .txnActive(inTxn),
      .suspendOpen(state == TX_SUSPEND),
      .depthFull(depth == MAX_NEST),
      .used128(used128),
      .used256(used256),
      .implEn(ctrl[`TAD_CTRL_IMPL_BIT]),
      .mixEn(ctrl[`TAD_CTRL_MIX_BIT]),
      .dirEn(ctrl[`TAD_CTRL_DIR_BIT]),
      .abortReq(clsAbort),
      .explicitAbort(explicitAbort)
   );

   // Next transaction state
   always_comb
   begin
      next_state = state;
      case (state)
         TX_IDLE:
         begin
            if (beginIdle)
               next_state = TX_ACTIVE;
         end
         TX_ACTIVE:
         begin
            if (abortNow || commitNow)
               next_state = TX_IDLE;
            else if (instrValid && instrClass == IC_SUSPEND)
               next_state = TX_SUSPEND;
         end
         TX_SUSPEND:
         begin
            if (abortNow)
               next_state = TX_IDLE;
            else if (instrValid && instrClass == IC_RESUME)
               next_state = TX_ACTIVE;
         end
         default: next_state = TX_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         state <= TX_IDLE;
      else
         state <= next_state;
   end

   // Nesting depth
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         depth <= '0;
      else if (abortNow)
         depth <= '0;
      else if (isBegin && state != TX_SUSPEND)
         depth <= depth + 1'b1;
      else if (isEnd && inTxn)
         depth <= depth - 1'b1;
   end

   // Pre-begin status snapshot for rollback
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         savedStatus <= 32'h00000000;
      else if (beginIdle)
         savedStatus <= abortStatusIn;
   end

   // Vector width usage in the current transaction
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || beginIdle)
      begin
         used128 <= 1'b0;
         used256 <= 1'b0;
      end
      else if (inTxn && instrValid)
      begin
         if (instrClass == IC_VEC128)
            used128 <= 1'b1;
         if (instrClass == IC_VEC256)
            used256 <= 1'b1;
      end
   end

   // Abort status value
   always_comb
   begin
      next_status = 32'h00000000;
      if (dbgHit && advMode)
         next_status = savedStatus;
      else if (dbgHit)
         next_status[`TAD_ST_DEBUG_BIT] = 1'b1;
      else if (explicitAbort)
      begin
         next_status[`TAD_ST_EXPLICIT_BIT] = 1'b1;
         next_status[`TAD_ST_ARG_LSB +: 8] = instrImm;
      end
   end

   // Abort outcome pulses
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         abortPulse <= 1'b0;
         fallbackPulse <= 1'b0;
         rollbackPulse <= 1'b0;
         dbgDeliver <= 1'b0;
         dbgStatusClr <= 1'b0;
      end
      else
      begin
         abortPulse <= abortNow;
         fallbackPulse <= abortNow & ~(dbgHit & advMode);
         rollbackPulse <= dbgHit & advMode;
         dbgDeliver <= dbgHit & advMode;
         dbgStatusClr <= dbgHit & advMode;
      end
   end

   // Abort status register, reloaded on each abort, and abort counter
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         abortStatus <= 32'h00000000;
         abortCount <= 32'h00000000;
      end
      else if (abortNow)
      begin
         abortStatus <= next_status;
         abortCount <= abortCount + 32'h00000001;
      end
   end

   // Commit is the only point state is released
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         archCommit <= 1'b0;
      else
         archCommit <= commitNow;
   end

   // Read set: suspended loads are left out
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         readSetAdd <= 1'b0;
         readSetAddr <= '0;
      end
      else
      begin
         readSetAdd <= loadValid & (state == TX_ACTIVE);
         readSetAddr <= loadAddr;
      end
   end

   assign txnActive = inTxn;
   assign suspendOpen = (state == TX_SUSPEND);

   // APB decode, zero wait states
   assign apbWr = psel & penable & pwrite;
   assign apbRd = psel & ~pwrite;
   assign mapped = (paddr == `TAD_REG_CTRL) || (paddr == `TAD_REG_STATUS)
                || (paddr == `TAD_REG_ABORT) || (paddr == `TAD_REG_COUNT);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Control register
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         ctrl <= `TAD_CTRL_RESET;
      else if (apbWr && paddr == `TAD_REG_CTRL)
         ctrl <= {29'h0, pwdata[2:0]};
   end

   // Read data captured in setup phase
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         prdata <= 32'h00000000;
      else if (apbRd && !penable)
      begin
         case (paddr)
            `TAD_REG_CTRL: prdata <= ctrl;
            `TAD_REG_STATUS: prdata <= {28'h0, advMode, suspendOpen,
                                        inTxn, archCommit};
            `TAD_REG_ABORT: prdata <= abortStatus;
            `TAD_REG_COUNT: prdata <= abortCount;
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_default_dbg: assert property (
      dbgHit && !advMode |=> fallbackPulse && abortStatus[4] && !dbgDeliver)
      else $error("default debug abort wrong");
   chk_adv_enable: assert property (
      dbgHit && !(debugControlReg[11] && debugCtlMsr[15]) |=> !rollbackPulse)
      else $error("advanced mode without both enables");
   chk_adv_restore: assert property (
      dbgHit && advMode |=> rollbackPulse && abortStatus == $past(savedStatus))
      else $error("rollback status not restored");
   chk_bp_delivers: assert property (
      bpExc && !dbgExc && inTxn && advMode |=> dbgDeliver && !fallbackPulse)
      else $error("breakpoint did not deliver debug");
   chk_dsr_clear: assert property (
      dbgStatusClr |-> dbgDeliver && rollbackPulse && !fallbackPulse
      && $past(advMode) && $past(inTxn))
      else $error("debug status bit not cleared");
   chk_suspend_load: assert property (
      state == TX_SUSPEND && loadValid |=> !readSetAdd)
      else $error("suspended load tracked");
   chk_resume_close: assert property (
      state == TX_SUSPEND && instrValid && instrClass == IC_RESUME
      && !dbgHit |=> state == TX_ACTIVE)
      else $error("resume did not close region");
   chk_begin_susp: assert property (
      state == TX_SUSPEND && (isBegin || isEnd) |=> abortPulse
      && state == TX_IDLE)
      else $error("begin or end in suspend not aborted");
   chk_nest_susp: assert property (
      state == TX_SUSPEND && instrValid && instrClass == IC_SUSPEND
      |=> abortPulse)
      else $error("nested suspend not aborted");
   chk_commit_only: assert property (
      archCommit |-> !abortPulse && $past(inTxn, 1))
      else $error("commit with abort");
   chk_always_abort: assert property (
      inTxn && instrValid && instrClass == IC_ALWAYS |=> abortPulse)
      else $error("always-abort class did not abort");
   chk_dir_same: assert property (
      inTxn && instrValid && instrClass == IC_DIR_SET && dirFlag && !dbgHit
      |=> !abortPulse)
      else $error("unchanged direction aborted");
   chk_explicit_arg: assert property (
      explicitAbort && !dbgHit |=> abortStatus[0]
      && abortStatus[31:24] == $past(instrImm))
      else $error("explicit abort status wrong");
endmodule
`default_nettype wire

// ### bench/tb_txn_abort_debug_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "tad_map.svh"
module tb_txn_abort_debug_control
   import tad_pkg::*;
();
   // Design inputs
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic instrValid = 1'b0, dirFlag = 1'b0, dbgExc = 1'b0, bpExc = 1'b0;
   tad_class_t instrClass = IC_NORMAL;
   logic [7:0] instrImm = 8'h00;
   logic [31:0] debugControlReg = 32'h0, debugCtlMsr = 32'h0;
   logic [31:0] abortStatusIn = 32'h0;
   logic loadValid = 1'b0;
   logic [47:0] loadAddr = 48'h0;
   // Design outputs
   logic [31:0] prdata, abortStatus;
   logic pready, pslverr, readSetAdd, txnActive, suspendOpen, abortPulse;
   logic fallbackPulse, rollbackPulse, dbgDeliver, dbgStatusClr, archCommit;
   logic [47:0] readSetAddr;
   // Reference model state
   int depth = 0, nAbort = 0, errors = 0, checked = 0;
   logic inSus = 1'b0, u128 = 1'b0, u256 = 1'b0;
   logic [31:0] ctrl = `TAD_CTRL_RESET, snap = 32'h0, expSt = 32'h0;

   tad_abort_ctrl dut (
      .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .instrValid, .instrClass, .instrImm,
      .dirFlag, .dbgExc, .bpExc, .debugControlReg, .debugCtlMsr,
      .abortStatusIn, .loadValid, .loadAddr, .readSetAdd, .readSetAddr,
      .txnActive, .suspendOpen, .abortPulse, .fallbackPulse, .rollbackPulse,
      .dbgDeliver, .dbgStatusClr, .archCommit, .abortStatus
   );

   // Clock
   always #4 ref_clk = ~ref_clk;

   // Comparisons
   task automatic cmp1(input string s, input logic g, input logic x);
      checked++;
      if (g !== x)
      begin
         errors++;
         $display("unexpected at %0t: %s got %b", $time, s, g);
      end
   endtask

   task automatic cmpW(input string s, input logic [47:0] g,
                       input logic [47:0] x);
      checked++;
      if (g !== x)
      begin
         errors++;
         $display("unexpected at %0t: %s got %h", $time, s, g);
      end
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for pready
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] x,
                        input logic e);
      logic [31:0] d;
      logic er;
      apb(1'b0, a, 32'h0, d, er);
      cmpW("read data", 48'(d), 48'(x));
      cmp1("slave error", er, e);
   endtask

   task automatic wrreg(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic er;
      apb(1'b1, a, wd, d, er);
      cmp1("write error", er, 1'b0);
   endtask

   // One retired instruction, optionally with an exception
   task automatic step(input tad_class_t c, input int exc);
      logic ab, kn, cm, rb, adv;
      logic [31:0] st, r;
      logic [7:0] imm;
      {ab, kn, cm, st} = 35'h0;
      imm = 8'($urandom);
      r = $urandom;
      @(posedge ref_clk);
      instrValid <= 1'b1;
      instrClass <= c;
      instrImm <= imm;
      dirFlag <= 1'($urandom);
      abortStatusIn <= r;
      dbgExc <= (exc == 1);
      bpExc <= (exc == 2);
      @(posedge ref_clk);
      adv = debugControlReg[11] & debugCtlMsr[15];
      if (depth > 0 && exc != 0)
      begin
         {ab, kn} = 2'b11;
         st = adv ? snap : 32'h00000010;
      end
      else if (depth > 0)
      begin
         case (c)
            IC_BEGIN: ab = inSus || depth == 7;
            IC_END: ab = inSus;
            IC_EXPL_ABORT: {ab, kn, st} = {2'b11, imm, 24'h000001};
            IC_ALWAYS: {ab, kn} = 2'b11;
            IC_SUSPEND: ab = inSus;
            IC_DIR_CLR: ab = ctrl[2] & dirFlag;
            IC_DIR_SET: ab = ctrl[2] & ~dirFlag;
            IC_VEC128: ab = ctrl[1] & u256;
            IC_VEC256: ab = ctrl[1] & u128;
            IC_IMPLDEP: ab = ctrl[0];
            default: ab = 1'b0;
         endcase
         if (!ab)
         begin
            depth = depth + (c == IC_BEGIN) - (c == IC_END);
            cm = (c == IC_END) && depth == 0;
            inSus = (inSus || c == IC_SUSPEND) && c != IC_RESUME;
            u128 = u128 | (c == IC_VEC128);
            u256 = u256 | (c == IC_VEC256);
         end
      end
      else if (c == IC_BEGIN)
      begin
         depth = 1;
         snap = r;
      end
      if (ab || cm)
      begin
         nAbort = nAbort + ab;
         depth = 0;
         {inSus, u128, u256} = 3'b000;
      end
      rb = ab && exc != 0 && adv;
      if (kn)
         expSt = st;
      instrValid <= 1'b0;
      dbgExc <= 1'b0;
      bpExc <= 1'b0;
      #1;
      cmp1("abort", abortPulse, ab);
      cmp1("fallback", fallbackPulse, ab & ~rb);
      cmp1("rollback", rollbackPulse, rb);
      cmp1("debug deliver", dbgDeliver, rb);
      cmp1("status clear", dbgStatusClr, rb);
      cmp1("commit", archCommit, cm);
      cmp1("active", txnActive, depth > 0);
      cmp1("suspend", suspendOpen, inSus);
      if (kn)
         cmpW("status", 48'(abortStatus), 48'(st));
   endtask

   // One load, checked against read set tracking
   task automatic ld(input logic [47:0] a);
      logic add;
      @(posedge ref_clk);
      loadValid <= 1'b1;
      loadAddr <= a;
      @(posedge ref_clk);
      add = depth > 0 && !inSus;
      loadValid <= 1'b0;
      loadAddr <= ~a;
      #1;
      cmp1("read set add", readSetAdd, add);
      if (add)
         cmpW("read set addr", readSetAddr, a);
   endtask

   // Main sequence
   initial
   begin
      logic [47:0] x;
      logic [31:0] r;
      int i, k;
      r = $urandom(32'h67B55B00);
      x = {16'h0, $urandom};
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdchk(`TAD_REG_CTRL, `TAD_CTRL_RESET, 1'b0);
      wrreg(`TAD_REG_ABORT, 32'hFFFFFFFF);
      rdchk(`TAD_REG_ABORT, 32'h0, 1'b0);
      rdchk(12'h010, 32'h0, 1'b1);
      wrreg(`TAD_REG_CTRL, 32'hFFFFFFF8);
      rdchk(`TAD_REG_CTRL, 32'h0, 1'b0);
      ctrl = 32'h0;
      $display("test registers done");
      for (k = 0; k < 2; k++)
      begin
         for (i = 0; i < 13; i++)
         begin
            step(IC_BEGIN, 0);
            step(IC_VEC128, 0);
            step(tad_class_t'(i), 0);
            step(tad_class_t'(i), 0);
            while (depth > 0)
               step(IC_END, 0);
         end
         wrreg(`TAD_REG_CTRL, `TAD_CTRL_RESET);
         ctrl = `TAD_CTRL_RESET;
      end
      $display("test classes done");
      for (i = 0; i < 8; i++)
         step(IC_BEGIN, 0);
      ld(x);
      step(IC_BEGIN, 0);
      ld(x);
      step(IC_SUSPEND, 0);
      ld(~x);
      ld(x);
      rdchk(`TAD_REG_STATUS, {29'h0, inSus, depth > 0, 1'b0}, 1'b0);
      step(IC_RESUME, 0);
      ld(~x);
      step(IC_END, 0);
      $display("test nesting and loads done");
      for (i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         r = $urandom;
         r[11] = i[0];
         debugControlReg <= r;
         r = $urandom;
         r[15] = i[1];
         debugCtlMsr <= r;
         step(IC_BEGIN, 0);
         step(IC_EXPL_ABORT, 1 + i[2]);
      end
      step(IC_EXPL_ABORT, 1);
      rdchk(`TAD_REG_ABORT, expSt, 1'b0);
      rdchk(`TAD_REG_COUNT, 32'(nAbort), 1'b0);
      $display("test debug done");
      wrap_up();
   end

   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
